// file: dv/count_source.sv
// partner model: bursts of rising edges on the external count input
`timescale 1ns/1ps
module count_source (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       start,
    input  wire logic [7:0] burst_len,
    input  wire logic [3:0] half_cycles,
    output logic            count_in,
    output logic            busy
);
    logic [7:0] left_reg;
    logic [3:0] phase_reg;

    // line rests low between bursts; half_cycles of 2 or more keeps the edge rate at quarter rate at most
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            count_in  <= 1'b0;
            busy      <= 1'b0;
            left_reg  <= 8'h00;
            phase_reg <= 4'h0;
        end else if (!busy) begin
            count_in <= 1'b0;
            if (start && burst_len != 8'h00) begin
                busy     <= 1'b1;
                left_reg <= burst_len;
            end
            phase_reg <= 4'h0;
        end else if (phase_reg == half_cycles - 4'h1) begin
            phase_reg <= 4'h0;
            count_in  <= ~count_in;
            if (count_in) begin
                left_reg <= left_reg - 8'h01;
                busy     <= (left_reg != 8'h01);
            end
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end
endmodule

// file: dv/tb_timer_counter.sv
// self-checking testbench for the timer/counter
`timescale 1ns/1ps
module tb_timer_counter;
    import timer_pkg::*;
    logic              ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0]        wb_sel_i, half_cycles;
    logic [31:0]       wb_dat_i, wb_dat_o, rd;
    logic              count_in, sleep_mode, timer_match_output, peripheral_event, irq, src_start, src_busy, match_q;
    logic [7:0]        burst_len;
    int                num_errors = 0, comparisons = 0, cycles = 0, rises = 0, last_rise = 0, gap = 0, r0;

    timer_counter dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_in(count_in), .sleep_mode(sleep_mode),
        .timer_match_output(timer_match_output), .peripheral_event(peripheral_event), .irq(irq));
    count_source src (.ref_clk(ref_clk), .rstn(rstn), .start(src_start), .burst_len(burst_len),
        .half_cycles(half_cycles), .count_in(count_in), .busy(src_busy));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        comparisons++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // samples on the falling edge, where registered outputs have settled
    always @(negedge ref_clk) begin
        cycles++;
        match_q <= timer_match_output;
        if (timer_match_output === 1'b1 && match_q === 1'b0) begin
            rises++;
            gap = cycles - last_rise;
            last_rise = cycles;
        end
        if (rstn) check_eq({31'h0, peripheral_event}, {31'h0, timer_match_output});
        if (cycles == 30000) begin
            num_errors++;
            wrap_up();
        end
    end

    // classic cycle: hold until ack is sampled high, release at that edge
    task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50) num_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic burst(input logic [7:0] n, input logic [3:0] h);
        int k = 0;
        @(posedge ref_clk);
        src_start   <= 1'b1;
        burst_len   <= n;
        half_cycles <= h;
        @(posedge ref_clk);
        src_start <= 1'b0;
        @(posedge ref_clk);
        while (src_busy !== 1'b0 && k < 2000) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (20) @(posedge ref_clk);
    endtask

    task automatic wait_irq(input int limit);
        int n = 0;
        while (irq !== 1'b1 && n < limit) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic t_reset;
        logic [4:0] adr [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
        logic [7:0] exp [7] = '{LOW_RST, HIGH_RST, CTRL_RST, CTRL_RST, 8'h00, MASK_RST, 8'h00};
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, adr[i], 8'h00);
            check_eq(rd, {24'h0, exp[i]});
        end
    endtask

    task automatic t_rw8;
        wb(1'b1, COUNT_LOW_OFS, 8'h5a);
        wb(1'b1, HIGH_BUF_OFS, 8'h33);
        wb(1'b1, CTRL_FIRST_OFS, 8'h2f);
        wb(1'b1, 5'h18, 8'h77);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_eq(rd, 32'h5a);
        wb(1'b0, HIGH_BUF_OFS, 8'h00);
        check_eq(rd, 32'h33);
        wb(1'b0, CTRL_FIRST_OFS, 8'h00);
        check_eq(rd, 32'h0f);
        wb(1'b0, 5'h18, 8'h00);
        check_eq(rd, 32'h0);
    endtask

    task automatic t_buf16;
        wb(1'b1, CTRL_FIRST_OFS, 8'h10);
        wb(1'b1, HIGH_BUF_OFS, 8'h12);
        wb(1'b1, COUNT_LOW_OFS, 8'h34);
        wb(1'b1, HIGH_BUF_OFS, 8'h77);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_eq(rd, 32'h34);
        wb(1'b0, HIGH_BUF_OFS, 8'h00);
        check_eq(rd, 32'h12);
    endtask

    task automatic t_count;
        wb(1'b1, CTRL_FIRST_OFS, 8'h00);
        wb(1'b1, CTRL_SECOND_OFS, 8'h20);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        wb(1'b1, CTRL_FIRST_OFS, 8'h80);
        burst(8'd5, 4'd4);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_eq(rd, 32'h05);
        wb(1'b1, CTRL_SECOND_OFS, 8'h21);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        burst(8'd6, 4'd4);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_eq(rd, 32'h03);
        sleep_mode <= 1'b1;
        wb(1'b1, CTRL_SECOND_OFS, 8'h30);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        burst(8'd4, 4'd2);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_eq(rd, 32'h04);
        sleep_mode <= 1'b0;
    endtask

    task automatic t_timer;
        wb(1'b1, CTRL_SECOND_OFS, 8'h00);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        repeat (160) @(posedge ref_clk);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_in(rd, 32'd38, 32'd41);
        wb(1'b1, CTRL_SECOND_OFS, 8'h03);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        repeat (320) @(posedge ref_clk);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_in(rd, 32'd9, 32'd10);
    endtask

    task automatic t_match;
        int k = 0;
        wb(1'b1, CTRL_FIRST_OFS, 8'h00);
        wb(1'b1, CTRL_SECOND_OFS, 8'h00);
        wb(1'b1, HIGH_BUF_OFS, 8'h03);
        wb(1'b1, COUNT_LOW_OFS, 8'h00);
        wb(1'b1, INT_MASK_OFS, 8'h01);
        wb(1'b1, CTRL_FIRST_OFS, 8'h80);
        wait_irq(1300);
        check_eq({31'h0, irq}, 32'h1);
        r0 = rises;
        while (rises < r0 + 2 && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
        check_eq(gap, 32'd16);
        wb(1'b1, INT_MASK_OFS, 8'h00);
        wb(1'b0, INT_STATUS_OFS, 8'h00);
        check_eq(rd, 32'h01);
        check_eq({31'h0, irq}, 32'h0);
        wb(1'b1, CTRL_FIRST_OFS, 8'h81);
        wb(1'b1, INT_STATUS_OFS, 8'h01);
        wb(1'b1, INT_MASK_OFS, 8'h01);
        wait_irq(100);
        // count matches between two postscaled flags, not from the control write
        wb(1'b1, INT_STATUS_OFS, 8'h01);
        r0 = rises;
        repeat (2) @(posedge ref_clk);
        check_eq({31'h0, irq}, 32'h0);
        wait_irq(100);
        check_eq(rises - r0, 32'd2);
    endtask

    task automatic t_ovf;
        wb(1'b1, CTRL_FIRST_OFS, 8'h10);
        wb(1'b1, INT_STATUS_OFS, 8'h01);
        wb(1'b1, HIGH_BUF_OFS, 8'hff);
        wb(1'b1, COUNT_LOW_OFS, 8'hfc);
        wb(1'b1, CTRL_FIRST_OFS, 8'h90);
        wait_irq(100);
        check_eq({31'h0, irq}, 32'h1);
        wb(1'b0, COUNT_LOW_OFS, 8'h00);
        check_in(rd, 32'h0, 32'h0f);
        wb(1'b0, HIGH_BUF_OFS, 8'h00);
        check_eq(rd, 32'h0);
        wb(1'b1, INT_STATUS_OFS, 8'h01);
        repeat (2) @(posedge ref_clk);
        check_eq({31'h0, irq}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        sleep_mode = 1'b0;
        src_start = 1'b0;
        burst_len = 8'h00;
        half_cycles = 4'h4;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_rw8();
        t_buf16();
        t_count();
        t_timer();
        t_match();
        t_ovf();
        wrap_up();
    end
endmodule

// file: verilog/event_prescaler.sv
// power-of-two event prescaler, 15-bit counter
`timescale 1ns/1ps
module event_prescaler
    import timer_pkg::*;
#(
    parameter int CNT_W = 15
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             clear,
    input  wire logic             event_in,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick_reg
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mask;

    assign mask = CNT_W'((CNT_W+1)'(1) << sel) - CNT_W'(1);

    always_ff @(posedge ref_clk) begin
        if (!rstn || clear) begin
            cnt_reg <= '0;
        end else if (event_in) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    // select zero bypasses the divider
    always_ff @(posedge ref_clk) begin
        if (!rstn || clear) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= event_in && ((cnt_reg & mask) == mask);
        end
    end

    property p_bypass;
        @(posedge ref_clk) disable iff (!rstn)
        (sel == '0 && event_in && !clear) |=> tick_reg;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed event did not tick");
endmodule

// file: verilog/timer_counter.sv
// 8/16-bit timer/counter with wishbone register slave
// Summary of operation
// - width select bit in first control chooses 8-bit or 16-bit counting.
// - count advances on selected source rising edge after 15-bit prescaler, 4-bit select.
// - 16-bit: real high byte hidden; low byte read loads high buffer.
// - 16-bit: low byte write loads real high byte from buffer.
// - 8-bit: low matches period; output pulses, low clears, period reloads.
// - 8-bit: both bytes read/write; reset clears low, sets high to ones.
// - low write, control writes and reset clear prescaler and postscaler.
// - counter mode, select zero: each input rising edge counts once.
// - timer mode counts instruction cycles, or divided rate with prescaler.
// - asynchronous select one counts input edges unsynchronised, also during sleep.
// - asynchronous select zero syncs to quarter rate; input must not exceed it.
// - interrupt flag raised on match or overflow after postscaler.
// - prescaler is private to the timer, not shared with watchdog.
// - timer event goes to a pin route and to on-chip peripherals.
`timescale 1ns/1ps
module timer_counter
    import timer_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              count_in,
    input  wire logic              sleep_mode,
    output logic                   timer_match_output,
    output logic                   peripheral_event,
    output logic                   irq
);
    import timer_pkg::*;

    logic [7:0] low_reg;
    logic [7:0] high_reg;
    logic [7:0] real_high_reg;
    logic [7:0] period_reg;
    logic [7:0] ctrl_first_reg;
    logic [7:0] ctrl_second_reg;
    logic [7:0] status_reg;
    logic [7:0] mask_reg;
    logic [3:0] post_cnt_reg;
    logic [1:0] phase_reg;
    logic       count_prev_reg;
    logic       ack_reg;
    logic [31:0] rdata_reg;
    logic       out_reg;
    logic       evt_out_reg;
    logic       irq_reg;

    logic       acc;
    logic       wr;
    logic       rd;
    logic       wr_low;
    logic       wr_ctrl;
    logic       instr_strobe;
    logic       in_edge;
    logic       raw_event;
    logic       src_event;
    logic       tick;
    logic       enabled;
    logic       mode16;
    logic       async_mode;
    logic       hit;
    logic       post_fire;
    logic [7:0] status_wclr;
    logic [7:0] rd_mux;

    // access takes effect on the edge where the master sees ack
    assign acc     = wb_cyc_i && wb_stb_i && ack_reg;
    assign wr      = acc && wb_we_i && wb_sel_i[0];
    assign rd      = acc && !wb_we_i;
    assign wr_low  = wr && (wb_adr_i == COUNT_LOW_OFS);
    assign wr_ctrl = wr && (wb_adr_i == CTRL_FIRST_OFS || wb_adr_i == CTRL_SECOND_OFS);

    assign enabled    = ctrl_first_reg[EN_BIT];
    assign mode16     = ctrl_first_reg[WIDTH_SEL_BIT];
    assign async_mode = ctrl_second_reg[ASYNC_BIT];

    // bus answer: one wait state, ack for one cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        unique case (wb_adr_i)
            COUNT_LOW_OFS:   rd_mux = low_reg;
            HIGH_BUF_OFS:    rd_mux = high_reg;
            CTRL_FIRST_OFS:  rd_mux = ctrl_first_reg;
            CTRL_SECOND_OFS: rd_mux = ctrl_second_reg;
            INT_STATUS_OFS:  rd_mux = status_reg;
            INT_MASK_OFS:    rd_mux = mask_reg;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            rdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_first_reg  <= CTRL_RST;
            ctrl_second_reg <= CTRL_RST;
            mask_reg        <= MASK_RST;
        end else if (wr) begin
            if (wb_adr_i == CTRL_FIRST_OFS) begin
                ctrl_first_reg <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
            end
            if (wb_adr_i == CTRL_SECOND_OFS) begin
                ctrl_second_reg <= {2'b00, wb_dat_i[5:0]};
            end
            if (wb_adr_i == INT_MASK_OFS) begin
                mask_reg <= wb_dat_i[7:0];
            end
        end
    end

    // instruction cycle strobe; the core clock halts in sleep
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            phase_reg <= 2'h0;
        end else if (!sleep_mode) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign instr_strobe = !sleep_mode && (phase_reg == INSTR_DIV_LAST);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            count_prev_reg <= 1'b0;
        end else begin
            count_prev_reg <= count_in;
        end
    end
    assign in_edge   = count_in && !count_prev_reg;
    assign raw_event = ctrl_second_reg[SRC_BIT] ? in_edge : instr_strobe;

    // synchronous mode holds an input edge until the next quarter-rate strobe
    logic sync_hold_reg;
    always_ff @(posedge ref_clk) begin
        if (!rstn || async_mode) begin
            sync_hold_reg <= 1'b0;
        end else if (instr_strobe) begin
            sync_hold_reg <= 1'b0;
        end else if (in_edge) begin
            sync_hold_reg <= 1'b1;
        end
    end

    always_comb begin
        if (!enabled) begin
            src_event = 1'b0;
        end else if (!ctrl_second_reg[SRC_BIT]) begin
            src_event = instr_strobe;
        end else if (async_mode) begin
            src_event = raw_event;
        end else begin
            src_event = instr_strobe && (sync_hold_reg || in_edge);
        end
    end

    // private prescaler instance, never shared with the watchdog
    event_prescaler #(
        .CNT_W (PRE_W)
    ) u_prescaler (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .clear    (wr_low || wr_ctrl),
        .event_in (src_event),
        .sel      (ctrl_second_reg[SEL_W-1:0]),
        .tick_reg (tick)
    );

    assign hit = mode16 ? ({real_high_reg, low_reg} == 16'hffff) : (low_reg == period_reg);

    // count bytes, high buffer and period buffer
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            low_reg       <= LOW_RST;
            high_reg      <= HIGH_RST;
            real_high_reg <= LOW_RST;
            period_reg    <= HIGH_RST;
        end else begin
            if (tick && enabled) begin
                if (mode16) begin
                    {real_high_reg, low_reg} <= {real_high_reg, low_reg} + 16'h0001;
                end else if (hit) begin
                    low_reg    <= 8'h00;
                    period_reg <= high_reg;
                end else begin
                    low_reg <= low_reg + 8'h01;
                end
            end
            if (wr_low) begin
                low_reg <= wb_dat_i[7:0];
                if (mode16) begin
                    real_high_reg <= high_reg;
                end
            end
            if (wr && wb_adr_i == HIGH_BUF_OFS) begin
                high_reg <= wb_dat_i[7:0];
            end else if (rd && wb_adr_i == COUNT_LOW_OFS && mode16) begin
                high_reg <= real_high_reg;
            end
        end
    end

    // output high for one prescaled period after match or overflow
    always_ff @(posedge ref_clk) begin
        if (!rstn || !enabled) begin
            out_reg     <= 1'b0;
            evt_out_reg <= 1'b0;
        end else if (tick) begin
            out_reg     <= hit;
            evt_out_reg <= hit;
        end
    end
    assign timer_match_output = out_reg;
    assign peripheral_event   = evt_out_reg;

    assign post_fire = tick && enabled && hit && (post_cnt_reg == ctrl_first_reg[SEL_W-1:0]);

    always_ff @(posedge ref_clk) begin
        if (!rstn || wr_low || wr_ctrl) begin
            post_cnt_reg <= 4'h0;
        end else if (tick && enabled && hit) begin
            post_cnt_reg <= post_fire ? 4'h0 : post_cnt_reg + 4'h1;
        end
    end

    // set wins over write-one-to-clear
    assign status_wclr = (wr && wb_adr_i == INT_STATUS_OFS) ? wb_dat_i[7:0] : 8'h00;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= (status_reg & ~status_wclr) | (8'(post_fire) << EVT_BIT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end
    assign irq = irq_reg;

    property p_ack_once;
        @(posedge ref_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");

    property p_read_latch;
        @(posedge ref_clk) disable iff (!rstn)
        (rd && wb_adr_i == COUNT_LOW_OFS && mode16) |=> (high_reg == $past(real_high_reg));
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("high buffer not loaded on low read");

    property p_write_pair;
        @(posedge ref_clk) disable iff (!rstn)
        (wr_low && mode16) |=> (real_high_reg == $past(high_reg)) && (low_reg == $past(wb_dat_i[7:0]));
    endproperty
    a_write_pair: assert property (p_write_pair) else $error("16-bit write not applied together");

    property p_match_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && enabled && !mode16 && hit && !wr_low) |=> (low_reg == 8'h00) && timer_match_output;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear and pulse");

    property p_wrap;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && enabled && mode16 && hit && !wr_low) |=> ({real_high_reg, low_reg} == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("16-bit count did not wrap");

    property p_clear_post;
        @(posedge ref_clk) disable iff (!rstn)
        (wr_low || wr_ctrl) |=> (post_cnt_reg == 4'h0) && !tick;
    endproperty
    a_clear_post: assert property (p_clear_post) else $error("scalers not cleared on write");

    property p_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (!tick && !wr_low) |=> $stable(low_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without a tick");

    property p_flag;
        @(posedge ref_clk) disable iff (!rstn)
        post_fire |=> status_reg[EVT_BIT] ##1 (irq == ($past(status_reg[EVT_BIT]) && $past(mask_reg[EVT_BIT])));
    endproperty
    a_flag: assert property (p_flag) else $error("postscaled event did not flag");

    property p_sync_rate;
        @(posedge ref_clk) disable iff (!rstn)
        (src_event && !async_mode) |-> instr_strobe;
    endproperty
    a_sync_rate: assert property (p_sync_rate) else $error("sync count off quarter rate");

    property p_reset_values;
        @(posedge ref_clk)
        !rstn |=> (low_reg == LOW_RST) && (high_reg == HIGH_RST) && (period_reg == HIGH_RST) && !irq;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values not applied");

    property p_period_reload;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && enabled && !mode16 && hit) |=> (period_reg == $past(high_reg));
    endproperty
    a_period_reload: assert property (p_period_reload) else $error("period buffer not reloaded on match");

    property p_out_drop;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && timer_match_output && !hit) |=> !timer_match_output;
    endproperty
    a_out_drop: assert property (p_out_drop) else $error("match output held past one period");

    property p_irq_masked;
        @(posedge ref_clk) disable iff (!rstn)
        ((status_reg & mask_reg) == 8'h00) |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt without unmasked status");

    // an input edge in synchronous mode must reach the prescaler by the next strobe
    property p_sync_keep;
        @(posedge ref_clk) disable iff (!rstn)
        (in_edge && enabled && ctrl_second_reg[SRC_BIT] && !async_mode && !sleep_mode) |-> ##[0:3] src_event;
    endproperty
    a_sync_keep: assert property (p_sync_keep) else $error("synchronised input edge lost");
endmodule

// file: verilog/timer_pkg.sv
// constants shared by the timer/counter design files
package timer_pkg;
    localparam int           DATA_W          = 8;
    localparam int           PRE_W           = 15;
    localparam int           SEL_W           = 4;
    localparam int           ADDR_W          = 5;
    // register byte addresses
    localparam logic [4:0]   COUNT_LOW_OFS   = 5'h00;
    localparam logic [4:0]   HIGH_BUF_OFS    = 5'h04;
    localparam logic [4:0]   CTRL_FIRST_OFS  = 5'h08;
    localparam logic [4:0]   CTRL_SECOND_OFS = 5'h0c;
    localparam logic [4:0]   INT_STATUS_OFS  = 5'h10;
    localparam logic [4:0]   INT_MASK_OFS    = 5'h14;
    // timer_control_first fields
    localparam int           EN_BIT          = 7;
    localparam int           OUT_BIT         = 5;
    localparam int           WIDTH_SEL_BIT   = 4;
    // timer_control_second fields
    localparam int           SRC_BIT         = 5;
    localparam int           ASYNC_BIT       = 4;
    // interrupt status bit
    localparam int           EVT_BIT         = 0;
    // reset values
    localparam logic [7:0]   LOW_RST         = 8'h00;
    localparam logic [7:0]   HIGH_RST        = 8'hff;
    localparam logic [7:0]   CTRL_RST        = 8'h00;
    localparam logic [7:0]   MASK_RST        = 8'h00;
    // last phase of the four reference clocks per instruction cycle (quarter rate)
    localparam logic [1:0]   INSTR_DIV_LAST  = 2'h3;
endpackage
